// File: rtl/phase_shedding_manager.sv
// Purpose: Decides active phase count, guards frequency and temperature
// Assumes: Sensor values arrive from logic on mclk; enables are pins
// Notes: Registers over AHB-Lite, zero wait states, OKAY always
// Operation
// - Never exceed programmed maximum phase count; code lets a minimum programmed above it win
// - Never go below programmed minimum count
// - Five add thresholds, one per extra phase
// - Add phase when current exceeds threshold
// - Drop phase below threshold minus hysteresis
// - Run maximum phases while voltage ramps
// - Add phases when switching frequency too high
// - Frequency guard on at reset, adjustable
// - Apply selected over-temperature response
// - Latched shutdown is reset response
// - Separate fault, warning, response settings
// - Enable phases in ascending order
// - Hiccup retries output every 1 ms; code holds off while the fault lasts, retries 1 ms after it clears
// - Spread active phases evenly in time
// - Up to five satellites plus main
//
// Implementation choices: the address map and register access over AHB-Lite.
module phase_shedding_manager (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic output_on_req,
  input wire logic ramp_done,
  input wire logic [phase_pkg::CUR_W-1:0] output_current_ripple_high,
  input wire logic [phase_pkg::CUR_W-1:0] output_current_mean,
  input wire logic [phase_pkg::FREQ_W-1:0] switch_freq,
  input wire logic [phase_pkg::TEMP_W-1:0] temperature,
  input wire logic [15:0] switch_period,
  output logic output_enable,
  output logic [phase_pkg::MAX_PHASES-1:0] phase_enable,
  output logic [phase_pkg::MAX_PHASES-1:0] phase_fire,
  output logic irq
);
  import phase_pkg::*;

  phase_ctl_if pc ();

  // Configuration registers
  logic [CNT_W-1:0] max_phase_count;
  logic [CNT_W-1:0] min_phase_count;
  logic [CUR_W-1:0] phase_add_threshold [ADD_THRESHOLDS];
  logic [CUR_W-1:0] phase_drop_hysteresis;
  logic [CUR_W-1:0] ripple_compensation_offset;
  logic [FREQ_W-1:0] freq_guard_coefficient;
  logic freq_guard_off;
  logic [TEMP_W-1:0] overtemp_fault_threshold;
  logic [TEMP_W-1:0] overtemp_warning_threshold;
  ot_action_t overtemp_fault_action;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] next_irq_status;
  logic [IRQ_W-1:0] irq_event;

  // Bus address phase capture
  logic dph_valid;
  logic dph_write;
  logic [7:0] dph_addr;
  logic addr_take;
  logic wr_now;
  logic rd_status_now;
  logic clear_req;

  assign addr_take = hsel && hready && htrans[1];
  assign wr_now = dph_valid && dph_write;
  assign clear_req = wr_now && dph_addr == OFS_CONTROL &&
                     hwdata[CTRL_CLEAR_BIT];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase register
  always_ff @(posedge mclk) begin
    if (rst) begin
      dph_valid <= 1'b0;
      dph_write <= 1'b0;
      dph_addr <= 8'h00;
    end else begin
      dph_valid <= addr_take;
      dph_write <= hwrite;
      dph_addr <= haddr[7:0];
    end
  end

  // Power state and phase count state
  pwr_state_t pwr;
  pwr_state_t next_pwr;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic ot_latched;
  logic next_ot_latched;
  logic [$clog2(RETRY_CYCLES)-1:0] retry_cnt;
  logic [$clog2(RETRY_CYCLES)-1:0] next_retry_cnt;
  logic warn_flag;
  logic fault_flag;
  logic guard_trip;
  logic [CUR_W-1:0] load_cur;
  logic [CUR_W-1:0] ripple_adj;
  logic [CUR_W-1:0] up_thr;
  logic [CUR_W-1:0] dn_thr;
  logic [FREQ_W+FREQ_W-1:0] guard_prod;
  logic at_top;
  logic at_bottom;

  // Larger of compensated peak and mean
  assign ripple_adj = (output_current_ripple_high > ripple_compensation_offset)
      ? output_current_ripple_high - ripple_compensation_offset : '0;
  assign load_cur = (ripple_adj > output_current_mean) ? ripple_adj
                    : output_current_mean;

  // Threshold for next phase and current one
  assign at_top = (count >= max_phase_count) ||
                  (count >= CNT_W'(MAX_PHASES));
  assign at_bottom = (count <= 3'h1);
  assign up_thr = at_top ? '1 : phase_add_threshold[count - 3'h1];
  assign dn_thr = at_bottom ? '0 :
      ((phase_add_threshold[count - 3'h2] > phase_drop_hysteresis)
       ? phase_add_threshold[count - 3'h2] - phase_drop_hysteresis : '0);

  assign guard_prod = {16'h0000, FREQ_LIMIT} *
                      {16'h0000, freq_guard_coefficient};
  assign guard_trip = !freq_guard_off &&
                      ({16'h0000, switch_freq} > (guard_prod >> 8));

  assign warn_flag = temperature > overtemp_warning_threshold;
  assign fault_flag = temperature > overtemp_fault_threshold;

  // Next power state, phase count and over-temperature latch
  always_comb begin
    next_pwr = pwr;
    next_count = count;
    next_ot_latched = ot_latched;
    next_retry_cnt = retry_cnt;
    if (fault_flag && overtemp_fault_action != OT_IGNORE) begin
      next_ot_latched = 1'b1;
      next_retry_cnt = '0;
    end else if (ot_latched) begin
      if (overtemp_fault_action == OT_HICCUP) begin
        if (retry_cnt == ($clog2(RETRY_CYCLES))'(RETRY_CYCLES - 1)) begin
          next_ot_latched = 1'b0;
          next_retry_cnt = '0;
        end else begin
          next_retry_cnt = retry_cnt + 1'b1;
        end
      end else if (clear_req && !output_on_req) begin
        // Latched: cleared and output re-enabled afterwards
        next_ot_latched = 1'b0;
      end
    end
    case (pwr)
      PWR_OFF: begin
        if (output_on_req && !ot_latched) begin
          next_pwr = PWR_RAMP_UP;
        end
      end
      PWR_RAMP_UP: begin
        if (ot_latched) begin
          next_pwr = PWR_OFF;
        end else if (!output_on_req) begin
          next_pwr = PWR_RAMP_DOWN;
        end else if (ramp_done) begin
          next_pwr = PWR_RUN;
        end
      end
      PWR_RUN: begin
        if (ot_latched) begin
          next_pwr = PWR_OFF;
        end else if (!output_on_req) begin
          next_pwr = PWR_RAMP_DOWN;
        end
      end
      PWR_RAMP_DOWN: begin
        if (ramp_done || ot_latched) begin
          next_pwr = PWR_OFF;
        end
      end
      default: begin
        next_pwr = PWR_OFF;
      end
    endcase
    if (pwr == PWR_RAMP_UP || pwr == PWR_RAMP_DOWN) begin
      next_count = max_phase_count;
    end else if (!at_top && (guard_trip || load_cur > up_thr)) begin
      next_count = count + 3'h1;
    end else if (!at_bottom && !guard_trip && load_cur < dn_thr) begin
      next_count = count - 3'h1;
    end
    if (next_count > max_phase_count) begin
      next_count = max_phase_count;
    end
    if (next_count < min_phase_count) begin
      next_count = min_phase_count;
    end
    // Main plus five satellites at most
    if (next_count > CNT_W'(MAX_PHASES)) begin
      next_count = CNT_W'(MAX_PHASES);
    end
    if (next_count == 3'h0) begin
      next_count = 3'h1;
    end
  end

  // Register power and phase state
  always_ff @(posedge mclk) begin
    if (rst) begin
      pwr <= PWR_OFF;
      count <= 3'h1;
      ot_latched <= 1'b0;
      retry_cnt <= '0;
    end else begin
      pwr <= next_pwr;
      count <= next_count;
      ot_latched <= next_ot_latched;
      retry_cnt <= next_retry_cnt;
    end
  end

  assign pc.active_count = count;
  assign pc.run = (pwr != PWR_OFF);
  assign phase_enable = pc.phase_en;
  assign output_enable = (pwr != PWR_OFF);

  phase_spreader u_spread (
    .mclk(mclk),
    .rst(rst),
    .switch_period(switch_period),
    .ctl(pc.spread),
    .phase_fire(phase_fire)
  );

  // Interrupt events; set wins over read clear
  assign irq_event[IRQ_PHASE_BIT] = (next_count != count);
  assign irq_event[IRQ_WARN_BIT] = warn_flag;
  assign irq_event[IRQ_FAULT_BIT] = fault_flag;
  assign irq_event[IRQ_GUARD_BIT] = guard_trip;
  assign rd_status_now = dph_valid && !dph_write &&
                         dph_addr == OFS_IRQ_STATUS;
  always_comb begin
    next_irq_status = (rd_status_now ? '0 : irq_status) | irq_event;
  end
  assign irq = |(irq_status & irq_mask);

  always_ff @(posedge mclk) begin
    if (rst) begin
      max_phase_count <= RST_MAX_COUNT;
      min_phase_count <= RST_MIN_COUNT;
      for (int i = 0; i < ADD_THRESHOLDS; i++) begin
        phase_add_threshold[i] <= RST_THR_STEP * CUR_W'(i + 1);
      end
      phase_drop_hysteresis <= RST_HYST;
      ripple_compensation_offset <= RST_RIPPLE_OFS;
      freq_guard_coefficient <= RST_GUARD_COEFF;
      freq_guard_off <= 1'b0;
      overtemp_fault_threshold <= RST_OT_FAULT;
      overtemp_warning_threshold <= RST_OT_WARN;
      overtemp_fault_action <= OT_LATCH;
      irq_mask <= '0;
      irq_status <= '0;
    end else begin
      irq_status <= next_irq_status;
      if (wr_now) begin
        case (dph_addr)
          OFS_MAX_COUNT: max_phase_count <= hwdata[CNT_W-1:0];
          OFS_MIN_COUNT: min_phase_count <= hwdata[CNT_W-1:0];
          OFS_HYST: phase_drop_hysteresis <= hwdata[CUR_W-1:0];
          OFS_RIPPLE_OFS: ripple_compensation_offset <= hwdata[CUR_W-1:0];
          OFS_GUARD: begin
            freq_guard_coefficient <= hwdata[FREQ_W-1:0];
            freq_guard_off <= hwdata[GUARD_OFF_BIT];
          end
          OFS_OT_FAULT: overtemp_fault_threshold <= hwdata[TEMP_W-1:0];
          OFS_OT_WARN: overtemp_warning_threshold <= hwdata[TEMP_W-1:0];
          OFS_OT_ACTION: begin
            overtemp_fault_action <= (hwdata[1:0] == 2'b11) ? OT_LATCH
                                     : ot_action_t'(hwdata[1:0]);
          end
          OFS_IRQ_MASK: irq_mask <= hwdata[IRQ_W-1:0];
          default: begin
            for (int i = 0; i < ADD_THRESHOLDS; i++) begin
              if (dph_addr == OFS_THR_BASE + 8'(4 * i)) begin
                phase_add_threshold[i] <= hwdata[CUR_W-1:0];
              end
            end
          end
        endcase
      end
    end
  end

  // Read data mux, registered at the address phase
  always_ff @(posedge mclk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_take && !hwrite) begin
      hrdata <= 32'h0000_0000;
      case (haddr[7:0])
        OFS_MAX_COUNT: hrdata <= {29'h0, max_phase_count};
        OFS_MIN_COUNT: hrdata <= {29'h0, min_phase_count};
        OFS_HYST: hrdata <= {16'h0000, phase_drop_hysteresis};
        OFS_RIPPLE_OFS: hrdata <= {16'h0000, ripple_compensation_offset};
        OFS_GUARD: hrdata <= {15'h0, freq_guard_off, freq_guard_coefficient};
        OFS_OT_FAULT: hrdata <= {16'h0000, overtemp_fault_threshold};
        OFS_OT_WARN: hrdata <= {16'h0000, overtemp_warning_threshold};
        OFS_OT_ACTION: hrdata <= {30'h0, overtemp_fault_action};
        OFS_STATUS: hrdata <= {24'h00_0000, pwr, ot_latched, fault_flag,
                               warn_flag, count};
        OFS_IRQ_STATUS: hrdata <= {28'h0, next_irq_status};
        OFS_IRQ_MASK: hrdata <= {28'h0, irq_mask};
        default: begin
          for (int i = 0; i < ADD_THRESHOLDS; i++) begin
            if (haddr[7:0] == OFS_THR_BASE + 8'(4 * i)) begin
              hrdata <= {16'h0000, phase_add_threshold[i]};
            end
          end
        end
      endcase
    end
  end
endmodule // phase_shedding_manager

// File: shared/phase_pkg.sv
// Purpose: Constants and types shared by the phase shedding manager
// Assumes: 100 MHz mclk, 32-bit AHB-Lite register bus
// Notes: Offsets are byte addresses of word registers
package phase_pkg;
  localparam int unsigned MAX_PHASES = 6;
  localparam int unsigned ADD_THRESHOLDS = 5;
  localparam int unsigned CUR_W = 16;
  localparam int unsigned TEMP_W = 16;
  localparam int unsigned FREQ_W = 16;
  localparam int unsigned CNT_W = 3;

  // Register byte offsets
  localparam logic [7:0] OFS_MAX_COUNT = 8'h00;
  localparam logic [7:0] OFS_MIN_COUNT = 8'h04;
  localparam logic [7:0] OFS_THR_BASE = 8'h08;
  localparam logic [7:0] OFS_HYST = 8'h1C;
  localparam logic [7:0] OFS_RIPPLE_OFS = 8'h20;
  localparam logic [7:0] OFS_GUARD = 8'h24;
  localparam logic [7:0] OFS_OT_FAULT = 8'h28;
  localparam logic [7:0] OFS_OT_WARN = 8'h2C;
  localparam logic [7:0] OFS_OT_ACTION = 8'h30;
  localparam logic [7:0] OFS_CONTROL = 8'h34;
  localparam logic [7:0] OFS_STATUS = 8'h38;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h3C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h40;

  // Guard register fields
  localparam int unsigned GUARD_OFF_BIT = 16;
  // Control register fields
  localparam int unsigned CTRL_CLEAR_BIT = 0;
  // Interrupt status bits
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_PHASE_BIT = 0;
  localparam int unsigned IRQ_WARN_BIT = 1;
  localparam int unsigned IRQ_FAULT_BIT = 2;
  localparam int unsigned IRQ_GUARD_BIT = 3;

  // Reset values
  localparam logic [CNT_W-1:0] RST_MAX_COUNT = 3'h6;
  localparam logic [CNT_W-1:0] RST_MIN_COUNT = 3'h1;
  localparam logic [CUR_W-1:0] RST_THR_STEP = 16'h0010;
  localparam logic [CUR_W-1:0] RST_HYST = 16'h0004;
  localparam logic [CUR_W-1:0] RST_RIPPLE_OFS = 16'h0002;
  localparam logic [FREQ_W-1:0] RST_GUARD_COEFF = 16'h0100;
  localparam logic [TEMP_W-1:0] RST_OT_FAULT = 16'h007D;
  localparam logic [TEMP_W-1:0] RST_OT_WARN = 16'h0073;
  // Fixed internal frequency threshold, before coefficient scaling
  localparam logic [FREQ_W-1:0] FREQ_LIMIT = 16'h0800;

  // Hiccup retry interval
  localparam int unsigned RETRY_US = 1000;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned RETRY_CYCLES = RETRY_US * CLK_MHZ;

  typedef enum logic [1:0] {
    OT_LATCH = 2'b00,
    OT_IGNORE = 2'b01,
    OT_HICCUP = 2'b10
  } ot_action_t;

  // Output power state, Gray coded along off-ramp-run-down
  typedef enum logic [1:0] {
    PWR_OFF = 2'b00,
    PWR_RAMP_UP = 2'b01,
    PWR_RUN = 2'b11,
    PWR_RAMP_DOWN = 2'b10
  } pwr_state_t;
endpackage

// File: shared/phase_ctl_if.sv
// Purpose: Carries the phase count from controller to interleaver
// Assumes: Single mclk domain
// Notes: Count is 1..6 active phases
interface phase_ctl_if;
  import phase_pkg::*;
  logic [CNT_W-1:0] active_count;
  logic [MAX_PHASES-1:0] phase_en;
  logic run;
  modport ctl (output active_count, output run, input phase_en);
  modport spread (input active_count, input run, output phase_en);
endinterface

// File: rtl/phase_spreader.sv
// Purpose: Enables phases in ascending order, spreads their instants
// Assumes: Switch period given in mclk cycles, divided among active phases
// Notes: Spacing is recomputed whenever the active count changes
module phase_spreader (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] switch_period,
  phase_ctl_if.spread ctl,
  output logic [phase_pkg::MAX_PHASES-1:0] phase_fire
);
  import phase_pkg::*;

  logic [15:0] spacing;
  logic [15:0] next_spacing;
  logic [15:0] tick;
  logic [15:0] next_tick;
  logic [CNT_W-1:0] slot;
  logic [CNT_W-1:0] next_slot;
  logic [CNT_W-1:0] last_count;
  logic [MAX_PHASES-1:0] next_fire;
  logic [MAX_PHASES-1:0] next_en;
  logic [MAX_PHASES-1:0] en_q;

  // Spacing, slot rotation and per-phase fire pulses
  always_comb begin
    next_spacing = spacing;
    next_tick = tick + 16'h0001;
    next_slot = slot;
    next_fire = '0;
    if (ctl.active_count != last_count || spacing == 16'h0000) begin
      next_spacing = switch_period / {13'h0000, ctl.active_count};
      next_tick = 16'h0000;
      next_slot = '0;
    end else if (tick + 16'h0001 >= spacing) begin
      next_tick = 16'h0000;
      next_fire[slot] = ctl.run;
      next_slot = (slot + 3'h1 >= ctl.active_count) ? 3'h0 : slot + 3'h1;
    end
  end

  generate
    for (genvar i = 0; i < MAX_PHASES; i++) begin : g_en
      assign next_en[i] = ctl.run && (i < ctl.active_count);
    end
  endgenerate

  // Register spreading state
  always_ff @(posedge mclk) begin
    if (rst) begin
      spacing <= 16'h0000;
      tick <= 16'h0000;
      slot <= '0;
      last_count <= '0;
      phase_fire <= '0;
      en_q <= '0;
    end else begin
      spacing <= next_spacing;
      tick <= next_tick;
      slot <= next_slot;
      last_count <= ctl.active_count;
      phase_fire <= next_fire;
      en_q <= next_en;
    end
  end

  assign ctl.phase_en = en_q;
endmodule // phase_spreader

// File: verification/phase_guard_sva.sv
// Purpose: Port checks for the phase shedding manager
// Assumes: One mclk domain, synchronous active high rst
// Notes: Bound to every manager instance
module phase_guard_sva (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic output_on_req,
  input wire logic output_enable,
  input wire logic [phase_pkg::MAX_PHASES-1:0] phase_enable,
  input wire logic [phase_pkg::MAX_PHASES-1:0] phase_fire
);
  import phase_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // Enables form one block upward from phase zero
  order_contig_a: assert property (
    (phase_enable & (phase_enable + 6'h01)) == '0)
    else $error("phase enables not contiguous");
  fire_single_a: assert property (
    $onehot0(phase_fire))
    else $error("more than one phase fired");
  fire_enabled_a: assert property (
    (phase_fire & ~(phase_enable | $past(phase_enable))) == '0)
    else $error("idle phase fired");
  off_clears_a: assert property (
    !output_enable |=> phase_enable == '0)
    else $error("phases left on with output off");
  on_cause_a: assert property (
    $rose(output_enable) |-> $past(output_on_req))
    else $error("output on without request");
  min_one_a: assert property (
    output_enable [*4] |-> phase_enable[0])
    else $error("no phase while output on");
  bus_ready_a: assert property (
    hreadyout)
    else $error("bus wait state inserted");
  bus_okay_a: assert property (
    hresp == 1'b0)
    else $error("bus error response");
endmodule // phase_guard_sva

bind phase_shedding_manager phase_guard_sva phase_guard_sva_inst (
  .mclk(mclk),
  .rst(rst),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .output_on_req(output_on_req),
  .output_enable(output_enable),
  .phase_enable(phase_enable),
  .phase_fire(phase_fire)
);

// File: verification/rail_stage_model.sv
// Purpose: Power stages that report the end of each soft ramp
// Assumes: Ramp starts on output enable rise or request fall
// Notes: RAMP sets a prompt or a slow stage
module rail_stage_model #(
  parameter int RAMP = 12
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic output_on_req,
  input wire logic output_enable,
  output logic ramp_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int left = 0;
  logic prev_en = 1'b0;
  logic prev_req = 1'b0;
  // Ramp timer, one-cycle done pulse at expiry
  always @(posedge mclk) begin
    prev_en <= output_enable;
    prev_req <= output_on_req;
    ramp_done <= 1'b0;
    if (rst) begin
      left <= 0;
    end else if ((output_enable && !prev_en) ||
                 (!output_on_req && prev_req)) begin
      left <= RAMP;
    end else if (left == 1) begin
      left <= 0;
      ramp_done <= 1'b1;
    end else if (left > 1) begin
      left <= left - 1;
    end
  end
endmodule // rail_stage_model

// File: verification/phase_shedding_manager_tb.sv
// Purpose: Self-checking bench for the phase shedding manager
// Assumes: AHB-Lite master tasks, zero wait state slave
// Notes: Hiccup wait makes the run about 100.5k cycles
module phase_shedding_manager_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import phase_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata, q;
  logic hreadyout, hresp, ramp_done, output_enable, irq;
  logic output_on_req = 1'b0;
  logic [CUR_W-1:0] ripple = '0;
  logic [CUR_W-1:0] mean = '0;
  logic [FREQ_W-1:0] switch_freq = '0;
  logic [TEMP_W-1:0] temperature = 16'h0020;
  logic [MAX_PHASES-1:0] phase_enable, phase_fire;
  logic [31:0] rv [13] = '{32'h6, 32'h1, 32'h10, 32'h20, 32'h30,
    32'h40, 32'h50, 32'h4, 32'h2, 32'h100, 32'h7D, 32'h73, 32'h0};
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  phase_shedding_manager phase_shedding_manager_inst (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .output_on_req(output_on_req), .ramp_done(ramp_done),
    .output_current_ripple_high(ripple),
    .output_current_mean(mean), .switch_freq(switch_freq),
    .temperature(temperature), .switch_period(16'h003C),
    .output_enable(output_enable), .phase_enable(phase_enable),
    .phase_fire(phase_fire), .irq(irq)
  );
  rail_stage_model rail_stage_model_inst (
    .mclk(mclk), .rst(rst), .output_on_req(output_on_req),
    .output_enable(output_enable), .ramp_done(ramp_done)
  );

  always #5 mclk = ~mclk;

  // Verdict and end of run
  task automatic conclude();
    if (n_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 120000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] got);
    checks_done++;
    if (got !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, got);
    end
  endtask

  // One single transfer: address phase, then data phase
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  // Sample a pin mid-cycle, resume on a rising edge
  task automatic look(input int s, input logic [31:0] e);
    @(negedge mclk);
    if (s == 0) chk("phase_enable", e, {26'h000_0000, phase_enable});
    else if (s == 1) chk("output_enable", e, {31'h0, output_enable});
    else chk("irq", e, {31'h0, irq});
    @(posedge mclk);
  endtask

  // Collect fire pulses over a window, compare the set seen
  task automatic fires(input logic [MAX_PHASES-1:0] e);
    logic [MAX_PHASES-1:0] seen;
    seen = '0;
    repeat (80) begin
      @(negedge mclk);
      seen = seen | phase_fire;
    end
    @(posedge mclk);
    chk("phase_fire", {26'h000_0000, e}, {26'h000_0000, seen});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Main sequence
  initial begin
    cyc(3);
    rst <= 1'b0;
    @(posedge mclk);
    foreach (rv[i]) begin
      bus(8'(4 * i), 1'b0, '0);
      chk("reset value", rv[i], q);
    end
    bus(8'h80, 1'b0, '0);
    chk("unmapped read", '0, q);
    bus(OFS_OT_FAULT, 1'b1, 32'h90);
    bus(OFS_OT_WARN, 1'b1, 32'h80);
    bus(OFS_OT_ACTION, 1'b1, 32'h1);
    bus(OFS_OT_WARN, 1'b0, '0);
    chk("warn limit", 32'h80, q);
    output_on_req <= 1'b1;
    cyc(4);
    look(0, 6'h3F);
    cyc(30);
    look(0, 6'h01);
    mean <= 16'h0011;
    cyc(8);
    look(0, 6'h03);
    mean <= 16'h0031;
    cyc(8);
    look(0, 6'h0F);
    mean <= 16'h002E;
    cyc(8);
    look(0, 6'h0F);
    mean <= 16'h002B;
    cyc(8);
    look(0, 6'h07);
    mean <= 16'h0000;
    ripple <= 16'h0032;
    cyc(8);
    look(0, 6'h07);
    ripple <= 16'h0033;
    cyc(8);
    look(0, 6'h0F);
    ripple <= 16'h0000;
    bus(OFS_MAX_COUNT, 1'b1, 32'h5);
    bus(OFS_MIN_COUNT, 1'b1, 32'h5);
    mean <= 16'h0100;
    cyc(8);
    look(0, 6'h1F);
    mean <= 16'h0000;
    bus(OFS_MIN_COUNT, 1'b1, 32'h3);
    cyc(8);
    look(0, 6'h07);
    fires(6'h07);
    bus(OFS_IRQ_MASK, 1'b1, '0);
    bus(OFS_IRQ_STATUS, 1'b0, '0);
    switch_freq <= 16'h0900;
    cyc(8);
    look(0, 6'h1F);
    look(2, 0);
    bus(OFS_IRQ_MASK, 1'b1, 32'h8);
    look(2, 1);
    bus(OFS_GUARD, 1'b1, 32'h0001_0100);
    cyc(8);
    look(0, 6'h07);
    bus(OFS_IRQ_STATUS, 1'b0, '0);
    chk("guard event", 32'h8, q & 32'h8);
    look(2, 0);
    switch_freq <= 16'h0000;
    temperature <= 16'h0085;
    cyc(4);
    bus(OFS_STATUS, 1'b0, '0);
    chk("temp flags", 32'h08, q & 32'h38);
    temperature <= 16'h00A0;
    cyc(4);
    bus(OFS_STATUS, 1'b0, '0);
    chk("temp flags", 32'h18, q & 32'h38);
    look(1, 1);
    bus(OFS_OT_ACTION, 1'b1, 32'h0);
    cyc(4);
    look(1, 0);
    temperature <= 16'h0020;
    cyc(20);
    look(1, 0);
    output_on_req <= 1'b0;
    cyc(20);
    bus(OFS_CONTROL, 1'b1, 32'h1);
    output_on_req <= 1'b1;
    cyc(4);
    look(1, 1);
    cyc(30);
    bus(OFS_OT_ACTION, 1'b1, 32'h2);
    temperature <= 16'h00A0;
    cyc(4);
    look(1, 0);
    temperature <= 16'h0020;
    cyc(90000);
    look(1, 0);
    cyc(10100);
    look(1, 1);
    conclude();
  end
endmodule // phase_shedding_manager_tb
